/* File: cscb_device.sv */
/*
  cscb_device: standby, clock-multiplier, clock-wait and reset-source
  registers, reset sequencing and clock output of the control block.
  Assumes the cpu side drives the wishbone master and interrupt state on
  clk_i; the reset pin and pll enable pin are asynchronous.
*/
// Register access over Wishbone is this design's own decision.
// How it works
// - reads answer in one clock, writes two
// - key 0x3C write then value changes protected registers
// - four zero-reset registers at consecutive word addresses
// - standby register write-only, two low bits
// - stop bit enters stop, clears on wake
// - halt bit stops cpu only, clears on wake
// - software never sets stop and halt together
// - standby writes ignored while leveled interrupt pending
// - standby writes ignored while unmasked fast interrupt pending
// - software clears flags or zeroes levels first
// - software clears fast flag or masks it first
// - low reset pin resets; release starts at zero
// - system clock divided by two driven onto clock output pin
// - high pll enable activates the pll
// - reset source reads 0 pin, 1 watchdog
// - internal reset lasts pin low plus nine clocks
// - watchdog keeps clock settings, clears standby
// - leveled, unmasked fast interrupt or reset wakes device
`timescale 1ns/1ps
module cscb_device
  import cscb_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  cscb_if.dev                          link,
  input  wire logic                    reset_pin_active_low_i,
  input  wire logic                    pll_enable_input_i,
  input  wire logic                    watchdog_overflow_i,
  output logic                         system_clock_output_pin_o,
  output logic                         pll_active_o,
  output logic [CSCB_FIELD_W-1:0]      clock_multiplier_o,
  output logic [CSCB_FIELD_W-1:0]      clock_wait_o,
  output logic                         stop_mode_o,
  output logic                         halt_mode_o,
  output logic                         sys_reset_o
);

  // pin synchronisers
  logic rpin_s1_r;
  logic rpin_s2_r;
  logic pll_s1_r;
  logic pll_s2_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rpin_s1_r <= 1'b1;
      rpin_s2_r <= 1'b1;
      pll_s1_r  <= 1'b0;
      pll_s2_r  <= 1'b0;
    end else begin
      rpin_s1_r <= reset_pin_active_low_i;
      rpin_s2_r <= rpin_s1_r;
      pll_s1_r  <= pll_enable_input_i;
      pll_s2_r  <= pll_s1_r;
    end
  end

  // reset sequencing
  logic       pin_low;
  logic [3:0] stretch_r;
  logic [3:0] stretch_nxt;
  logic       sys_reset_r;
  logic       sys_reset_nxt;
  logic       rst_src_r;

  assign pin_low = ~rpin_s2_r;

  always_comb begin
    if (pin_low) begin
      stretch_nxt = CSCB_RESET_STRETCH;
    end else if (watchdog_overflow_i) begin
      stretch_nxt = CSCB_RESET_STRETCH - 4'h1;
    end else if (stretch_r != 4'h0) begin
      stretch_nxt = stretch_r - 4'h1;
    end else begin
      stretch_nxt = 4'h0;
    end
  end

  assign sys_reset_nxt = pin_low | watchdog_overflow_i | (stretch_r != 4'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stretch_r   <= 4'h0;
      sys_reset_r <= 1'b0;
      rst_src_r   <= 1'b0;
    end else begin
      stretch_r   <= stretch_nxt;
      sys_reset_r <= sys_reset_nxt;
      if (pin_low) begin
        rst_src_r <= CSCB_RSTSRC_PIN[0];
      end else if (watchdog_overflow_i) begin
        rst_src_r <= CSCB_RSTSRC_WDT[0];
      end
    end
  end

  // pending interrupt detection
  logic [CSCB_IRQ_SRCS-1:0] src_pend;
  logic                     irq_pend;
  logic                     fiq_pend;
  logic                     wake;

  genvar gi;
  generate
    for (gi = 0; gi < CSCB_IRQ_SRCS; gi++) begin : g_pend
      assign src_pend[gi] = link.irq_flags[gi]
                            & (link.irq_levels[gi*CSCB_LEVEL_W +: CSCB_LEVEL_W] != '0);
    end
  endgenerate

  assign irq_pend = |src_pend;
  assign fiq_pend = link.fiq_flag & ~link.fiq_mask;
  assign wake     = irq_pend | fiq_pend;

  // register bus decode
  logic        ack_r;
  logic        wr_wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] wmask;
  logic [31:0] wdata;
  logic        start;
  logic        commit;
  logic        sel_stby;
  logic        sel_cmul;
  logic        sel_cwait;
  logic        sel_rsrc;
  logic        is_key;
  logic        stby_ok;

  assign start     = link.cyc & link.stb & ~ack_r & ~wr_wait_r;
  // a write lands at the edge where the master sees ack
  assign commit    = ack_r & link.cyc & link.stb & link.we & ~sys_reset_r;
  assign sel_stby  = (link.adr == CSCB_ADDR_STANDBY);
  assign sel_cmul  = (link.adr == CSCB_ADDR_CLKMUL);
  assign sel_cwait = (link.adr == CSCB_ADDR_CLKWAIT);
  assign sel_rsrc  = (link.adr == CSCB_ADDR_RSTSRC);
  assign wmask     = {{8{link.sel[3]}}, {8{link.sel[2]}}, {8{link.sel[1]}}, {8{link.sel[0]}}};
  assign wdata     = link.dat_w & wmask;
  assign is_key    = (wdata == CSCB_KEY);
  assign stby_ok   = ~irq_pend & ~fiq_pend;

  always_comb begin
    rdata_nxt = CSCB_REG_RESET;
    if (sel_cmul) begin
      rdata_nxt[CSCB_FIELD_W-1:0] = clock_multiplier_o;
    end else if (sel_cwait) begin
      rdata_nxt[CSCB_FIELD_W-1:0] = clock_wait_o;
    end else if (sel_rsrc) begin
      rdata_nxt[0] = rst_src_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r     <= 1'b0;
      wr_wait_r <= 1'b0;
      rdata_r   <= CSCB_REG_RESET;
    end else begin
      ack_r     <= (start & ~link.we) | wr_wait_r;
      wr_wait_r <= start & link.we;
      if (start & ~link.we) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // protected and plain registers
  logic                    stby_armed_r;
  logic                    cmul_armed_r;
  logic                    stop_r;
  logic                    halt_r;
  logic [CSCB_FIELD_W-1:0] cmul_r;
  logic [CSCB_FIELD_W-1:0] cwait_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || pin_low) begin
      stby_armed_r <= 1'b0;
      cmul_armed_r <= 1'b0;
      stop_r       <= 1'b0;
      halt_r       <= 1'b0;
      cmul_r       <= CSCB_REG_RESET[CSCB_FIELD_W-1:0];
      cwait_r      <= CSCB_REG_RESET[CSCB_FIELD_W-1:0];
    end else if (sys_reset_r) begin
      // watchdog reset clears standby but keeps clock settings
      stby_armed_r <= 1'b0;
      cmul_armed_r <= 1'b0;
      stop_r       <= 1'b0;
      halt_r       <= 1'b0;
    end else begin
      if (wake) begin
        stop_r <= 1'b0;
        halt_r <= 1'b0;
      end
      if (commit && sel_stby) begin
        stby_armed_r <= ~stby_armed_r & is_key;
        if (stby_armed_r && stby_ok) begin
          stop_r <= wdata[CSCB_STOP_BIT];
          halt_r <= wdata[CSCB_HALT_BIT] & ~wdata[CSCB_STOP_BIT];
        end
      end
      if (commit && sel_cmul) begin
        cmul_armed_r <= ~cmul_armed_r & is_key;
        if (cmul_armed_r) begin
          cmul_r <= wdata[CSCB_FIELD_W-1:0];
        end
      end
      if (commit && sel_cwait) begin
        cwait_r <= wdata[CSCB_FIELD_W-1:0];
      end
    end
  end

  // output registers
  logic clk_out_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_out_r <= 1'b0;
    end else begin
      clk_out_r <= ~clk_out_r;
    end
  end

  assign system_clock_output_pin_o = clk_out_r;
  assign pll_active_o              = pll_s2_r;
  assign clock_multiplier_o        = cmul_r;
  assign clock_wait_o              = cwait_r;
  assign stop_mode_o               = stop_r;
  assign halt_mode_o               = halt_r;
  assign sys_reset_o               = sys_reset_r;

  assign link.ack       = ack_r;
  assign link.dat_r     = rdata_r;
  assign link.cpu_halt  = halt_r | stop_r;
  assign link.sys_stop  = stop_r;
  assign link.sys_reset = sys_reset_r;

endmodule

/* File: cscb_pkg.sv */
/*
  cscb_pkg: shared constants of the cpu standby control block.
  Assumes a 32-bit word bus and a 100 MHz system clock.
*/
package cscb_pkg;
  localparam logic [31:0] CSCB_ADDR_STANDBY  = 32'h0040_0000;
  localparam logic [31:0] CSCB_ADDR_CLKMUL   = 32'h0040_0004;
  localparam logic [31:0] CSCB_ADDR_CLKWAIT  = 32'h0040_0008;
  localparam logic [31:0] CSCB_ADDR_RSTSRC   = 32'h0040_000C;
  localparam logic [31:0] CSCB_KEY           = 32'h0000_003C;
  localparam logic [31:0] CSCB_REG_RESET     = 32'h0000_0000;
  localparam logic [31:0] CSCB_RSTSRC_PIN    = 32'h0000_0000;
  localparam logic [31:0] CSCB_RSTSRC_WDT    = 32'h0000_0001;
  localparam int          CSCB_STOP_BIT      = 1;
  localparam int          CSCB_HALT_BIT      = 0;
  localparam int          CSCB_FIELD_W       = 2;
  localparam logic [3:0]  CSCB_RESET_STRETCH = 4'h9;
  localparam int          CSCB_IRQ_SRCS      = 8;
  localparam int          CSCB_LEVEL_W       = 3;
  localparam logic [31:0] CSCB_EXEC_START    = 32'h0000_0000;
  localparam logic [31:0] CSCB_PC_STEP       = 32'h0000_0004;
endpackage

/* File: cscb_if.sv */
/*
  cscb_if: link between the control block and the cpu side.
  Assumes both ends run on the same clock; carries a classic
  wishbone register bus plus interrupt state and standby/reset status.
*/
`timescale 1ns/1ps
interface cscb_if;
  import cscb_pkg::*;
  logic                                  cyc;
  logic                                  stb;
  logic                                  we;
  logic [31:0]                           adr;
  logic [3:0]                            sel;
  logic [31:0]                           dat_w;
  logic [31:0]                           dat_r;
  logic                                  ack;
  logic [CSCB_IRQ_SRCS-1:0]              irq_flags;
  logic [CSCB_IRQ_SRCS*CSCB_LEVEL_W-1:0] irq_levels;
  logic                                  fiq_flag;
  logic                                  fiq_mask;
  logic                                  cpu_halt;
  logic                                  sys_stop;
  logic                                  sys_reset;
  modport dev (input cyc, stb, we, adr, sel, dat_w, irq_flags, irq_levels, fiq_flag,
               fiq_mask, output dat_r, ack, cpu_halt, sys_stop, sys_reset);
  modport host (output cyc, stb, we, adr, sel, dat_w, irq_flags, irq_levels, fiq_flag,
                fiq_mask, input dat_r, ack, cpu_halt, sys_stop, sys_reset);
endinterface

/* File: cscb_host.sv */
/*
  cscb_host: cpu-side end of the control block link.
  Assumes commands and interrupt state come from logic on clk_i; it
  masters the wishbone bus and models the fetch address of the core.
*/
`timescale 1ns/1ps
module cscb_host
  import cscb_pkg::*;
(
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  cscb_if.host                                       link,
  input  wire logic                                  cmd_valid_i,
  input  wire logic                                  cmd_we_i,
  input  wire logic [31:0]                           cmd_addr_i,
  input  wire logic [31:0]                           cmd_wdata_i,
  input  wire logic [CSCB_IRQ_SRCS-1:0]              irq_flags_i,
  input  wire logic [CSCB_IRQ_SRCS*CSCB_LEVEL_W-1:0] irq_levels_i,
  input  wire logic                                  fiq_flag_i,
  input  wire logic                                  fiq_mask_i,
  output logic                                       cmd_ready_o,
  output logic                                       rsp_valid_o,
  output logic [31:0]                                rsp_rdata_o,
  output logic [31:0]                                exec_pc_o,
  output logic                                       cpu_running_o
);

  typedef enum logic [1:0] {H_IDLE, H_BUS, H_GAP} cscb_hstate_t;

  cscb_hstate_t state_r;
  cscb_hstate_t state_nxt;
  logic         suspended;
  logic         take;
  logic         both_bits;
  logic         ready_r;
  logic [31:0]  pc_r;
  logic         cyc_r;
  logic         we_r;
  logic [31:0]  adr_r;
  logic [31:0]  dat_w_r;
  logic         rsp_r;
  logic [31:0]  rdata_r;

  assign suspended = link.cpu_halt | link.sys_reset;
  assign take      = cmd_valid_i & ready_r;
  // a standby write with both request bits set is dropped here
  assign both_bits = cmd_we_i & (cmd_addr_i == CSCB_ADDR_STANDBY)
                     & cmd_wdata_i[CSCB_STOP_BIT] & cmd_wdata_i[CSCB_HALT_BIT];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      H_IDLE: begin
        if (take && !both_bits) begin
          state_nxt = H_BUS;
        end
      end
      H_BUS: begin
        if (link.ack) begin
          state_nxt = H_GAP;
        end
      end
      H_GAP: begin
        state_nxt = H_IDLE;
      end
      default: begin
        state_nxt = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= H_IDLE;
      ready_r <= 1'b0;
      cyc_r   <= 1'b0;
      we_r    <= 1'b0;
      adr_r   <= CSCB_REG_RESET;
      dat_w_r <= CSCB_REG_RESET;
      rsp_r   <= 1'b0;
      rdata_r <= CSCB_REG_RESET;
    end else begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == H_IDLE) & ~suspended & ~(take & both_bits);
      rsp_r   <= 1'b0;
      if (state_r == H_IDLE && take) begin
        cyc_r   <= ~both_bits;
        we_r    <= cmd_we_i;
        adr_r   <= cmd_addr_i;
        dat_w_r <= cmd_wdata_i;
        rsp_r   <= both_bits;
        rdata_r <= CSCB_REG_RESET;
      end else if (state_r == H_BUS && link.ack) begin
        cyc_r   <= 1'b0;
        rsp_r   <= 1'b1;
        rdata_r <= we_r ? CSCB_REG_RESET : link.dat_r;
      end
    end
  end

  // fetch address restarts from zero after any system reset
  always_ff @(posedge clk_i) begin
    if (rst_i || link.sys_reset) begin
      pc_r <= CSCB_EXEC_START;
    end else if (!link.cpu_halt) begin
      pc_r <= pc_r + CSCB_PC_STEP;
    end
  end

  assign link.cyc        = cyc_r;
  assign link.stb        = cyc_r;
  assign link.we         = we_r;
  assign link.adr        = adr_r;
  assign link.sel        = 4'hF;
  assign link.dat_w      = dat_w_r;
  assign link.irq_flags  = irq_flags_i;
  assign link.irq_levels = irq_levels_i;
  assign link.fiq_flag   = fiq_flag_i;
  assign link.fiq_mask   = fiq_mask_i;

  assign cmd_ready_o   = ready_r;
  assign rsp_valid_o   = rsp_r;
  assign rsp_rdata_o   = rdata_r;
  assign exec_pc_o     = pc_r;
  assign cpu_running_o = ~suspended;

endmodule

/* File: cscb_props.sv */
/*
  cscb_props: timing checks on the host/device link of the control block.
  Assumes one clock clk_i and the synchronous active-high reset rst_i.
*/
`timescale 1ns/1ps
module cscb_props
  import cscb_pkg::*;
(
  input wire logic                                  clk_i,
  input wire logic                                  rst_i,
  input wire logic                                  cyc,
  input wire logic                                  stb,
  input wire logic                                  we,
  input wire logic [31:0]                           adr,
  input wire logic [31:0]                           dat_r,
  input wire logic                                  ack,
  input wire logic [CSCB_IRQ_SRCS-1:0]              irq_flags,
  input wire logic [CSCB_IRQ_SRCS*CSCB_LEVEL_W-1:0] irq_levels,
  input wire logic                                  fiq_flag,
  input wire logic                                  fiq_mask,
  input wire logic                                  cpu_halt,
  input wire logic                                  sys_stop,
  input wire logic                                  sys_reset
);
  logic lvl_pend;
  wire  fiq_pend = fiq_flag && !fiq_mask;
  wire  wake     = lvl_pend || fiq_pend || sys_reset;
  wire  sby_wr   = cyc && stb && we && (adr == CSCB_ADDR_STANDBY);
  logic [3:0] rst_run_r;

  // consecutive cycles of internal reset, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || !sys_reset) begin
      rst_run_r <= 4'h0;
    end else if (rst_run_r != 4'hF) begin
      rst_run_r <= rst_run_r + 4'h1;
    end
  end

  // any source with its flag up and a nonzero level
  always_comb begin
    lvl_pend = 1'b0;
    for (int i = 0; i < CSCB_IRQ_SRCS; i++) begin
      if (irq_flags[i] && (irq_levels[i*CSCB_LEVEL_W +: CSCB_LEVEL_W] != '0)) begin
        lvl_pend = 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  rd_ack_a: assert property ($rose(cyc && stb) && !we |=> ack)
    else $error("read not answered in one cycle");
  wr_ack_a: assert property ($rose(cyc && stb) && we |=> !ack ##1 ack)
    else $error("write not answered in two cycles");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  halt_entry_a: assert property ($rose(cpu_halt) |-> $past(sby_wr))
    else $error("halt entered without a standby write");
  stop_entry_a: assert property ($rose(sys_stop) |-> $past(sby_wr))
    else $error("stop entered without a standby write");
  lvl_block_a: assert property ($rose(cpu_halt) |-> !$past(lvl_pend))
    else $error("standby entered with a leveled request pending");
  fiq_block_a: assert property ($rose(cpu_halt) |-> !$past(fiq_pend))
    else $error("standby entered with a fast request pending");
  wake_clear_a: assert property (cpu_halt && wake |=> !cpu_halt)
    else $error("standby not left after wake");
  rst_len_a: assert property ($fell(sys_reset) |-> rst_run_r >= CSCB_RESET_STRETCH)
    else $error("internal reset shorter than nine cycles");
  src_bits_a: assert property (ack && !we && adr == CSCB_ADDR_RSTSRC |-> dat_r[31:1] == '0)
    else $error("reset source upper bits not zero");
  stop_halt_a: assert property (sys_stop |-> cpu_halt)
    else $error("stop without cpu suspended");

  cover property ($rose(cpu_halt) && !sys_stop);
  cover property ($rose(sys_stop));
  cover property ($rose(sys_reset));
endmodule

/* File: cscb_bench.sv */
/*
  cscb_bench: self-checking bench joining the host and device ends.
  Assumes cscb_pkg, cscb_if, cscb_host, cscb_device and cscb_props.
*/
`timescale 1ns/1ps
module cscb_bench;
  import cscb_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, c_v = 1'b0, c_we = 1'b0, fq = 1'b0, fm = 1'b0;
  logic rst_pin_n = 1'b1, pll = 1'b1, wdog = 1'b0, b;
  logic [31:0] c_a = '0, c_d = '0, q, rd_d, pc;
  logic [7:0] irf = '0;
  logic [23:0] irl = '0;
  logic rdy, rv, run, ck_o, pll_o, stop_request_bit, halt_request_bit, sr;
  logic [1:0] mul_o, wt_o;
  int n_errors = 0, checks_done = 0, mul = 0, wt = 0, src = 0, s, lv, v, n;
  int arm [2] = '{0, 0};
  cscb_if lk ();
  cscb_host u_cscb_host (.clk_i, .rst_i, .link(lk.host), .cmd_valid_i(c_v), .cmd_we_i(c_we),
    .cmd_addr_i(c_a), .cmd_wdata_i(c_d), .irq_flags_i(irf), .irq_levels_i(irl),
    .fiq_flag_i(fq), .fiq_mask_i(fm), .cmd_ready_o(rdy), .rsp_valid_o(rv),
    .rsp_rdata_o(rd_d), .exec_pc_o(pc), .cpu_running_o(run));
  cscb_device u_cscb_device (.clk_i, .rst_i, .link(lk.dev), .reset_pin_active_low_i(rst_pin_n),
    .pll_enable_input_i(pll), .watchdog_overflow_i(wdog), .system_clock_output_pin_o(ck_o),
    .pll_active_o(pll_o), .clock_multiplier_o(mul_o), .clock_wait_o(wt_o),
    .stop_mode_o(stop_request_bit), .halt_mode_o(halt_request_bit), .sys_reset_o(sr));
  cscb_props u_cscb_props (.clk_i, .rst_i, .cyc(lk.cyc), .stb(lk.stb), .we(lk.we),
    .adr(lk.adr), .dat_r(lk.dat_r), .ack(lk.ack), .irq_flags(lk.irq_flags),
    .irq_levels(lk.irq_levels), .fiq_flag(lk.fiq_flag), .fiq_mask(lk.fiq_mask),
    .cpu_halt(lk.cpu_halt), .sys_stop(lk.sys_stop), .sys_reset(lk.sys_reset));
  always #5 clk_i = ~clk_i;

  task automatic chk(string w, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, exp, seen);
    end
  endtask
  // command is held until taken, then the response pulse is caught
  task automatic cmd(logic we, logic [31:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    c_v <= 1'b1;
    c_we <= we;
    c_a <= a;
    c_d <= d;
    do @(negedge clk_i); while (rdy !== 1'b1 && ++k < 300);
    @(posedge clk_i);
    c_v <= 1'b0;
    do @(negedge clk_i); while (rv !== 1'b1 && ++k < 300);
    q = rd_d;
    if (k >= 300) chk("command wait", 32'h0, 32'h1);
  endtask
  // model: a key arms, the next write there is applied only if armed
  task automatic wr(logic [31:0] a, logic [31:0] d);
    int i;
    i = (a == CSCB_ADDR_CLKMUL) ? 1 : 0;
    cmd(1'b1, a, d);
    if (a == CSCB_ADDR_CLKWAIT) wt = d & 3;
    else if (a == CSCB_ADDR_CLKMUL || a == CSCB_ADDR_STANDBY) begin
      if (arm[i] != 0 && i == 1) mul = d & 3;
      arm[i] = (arm[i] == 0 && d == CSCB_KEY);
    end
  endtask
  task automatic rd(logic [31:0] a);
    int e;
    e = a == CSCB_ADDR_CLKMUL ? mul : a == CSCB_ADDR_CLKWAIT ? wt : a == CSCB_ADDR_RSTSRC ? src : 0;
    cmd(1'b0, a, 32'h0);
    chk("read data", q, e);
  endtask
  task automatic irq(logic [7:0] f, logic [23:0] l, logic ff, logic fmk);
    @(posedge clk_i);
    irf <= f;
    irl <= l;
    fq <= ff;
    fm <= fmk;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hAF3F3544));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CSCB_ADDR_CLKMUL);
    rd(CSCB_ADDR_CLKWAIT);
    rd(CSCB_ADDR_RSTSRC);
    v = $urandom_range(3, 1);
    wr(CSCB_ADDR_CLKMUL, v);
    rd(CSCB_ADDR_CLKMUL);
    wr(CSCB_ADDR_CLKMUL, CSCB_KEY);
    wr(CSCB_ADDR_CLKMUL, v);
    rd(CSCB_ADDR_CLKMUL);
    chk("multiplier pins", mul_o, v);
    wr(CSCB_ADDR_CLKMUL, CSCB_KEY);
    wr(CSCB_ADDR_CLKMUL, CSCB_KEY);
    wr(CSCB_ADDR_CLKMUL, v);
    rd(CSCB_ADDR_CLKMUL);
    wr(CSCB_ADDR_CLKWAIT, $urandom_range(3));
    rd(CSCB_ADDR_CLKWAIT);
    wr(CSCB_ADDR_RSTSRC, 32'h1);
    rd(CSCB_ADDR_RSTSRC);
    wr(32'h0040_0010, $urandom);
    rd(32'h0040_0010);
    $display("test registers done");
    // even k enters standby, odd k is blocked by a pending request
    for (int k = 0; k < 5; k++) begin
      s = $urandom_range(7);
      lv = $urandom_range(7, 1);
      case (k)
        0: irq(8'h00, 24'h0, 1'b0, 1'b0);
        1: irq(8'h01 << s, 24'(lv) << (3 * s), 1'b0, 1'b0);
        2: irq(8'h01 << s, 24'h0, 1'b0, 1'b0);
        3: irq(8'h00, 24'h0, 1'b1, 1'b0);
        default: irq(8'h00, 24'h0, 1'b1, 1'b1);
      endcase
      v = (k < 3) ? 1 : 2;
      wr(CSCB_ADDR_STANDBY, CSCB_KEY);
      wr(CSCB_ADDR_STANDBY, v);
      repeat (3) @(negedge clk_i);
      chk("standby mode", {stop_request_bit, halt_request_bit}, k % 2 ? 0 : v);
      chk("cpu running", run, k % 2);
      if (k == 2) irq(8'h01 << s, 24'(lv) << (3 * s), 1'b0, 1'b1);
      else irq(irf, irl, 1'b1, 1'b0);
      repeat (4) @(negedge clk_i);
      chk("woken", {stop_request_bit, halt_request_bit, run}, 1);
      irq(8'h00, 24'h0, 1'b0, 1'b0);
    end
    wr(CSCB_ADDR_STANDBY, CSCB_KEY);
    cmd(1'b1, CSCB_ADDR_STANDBY, 32'h3);
    chk("both bits refused", {stop_request_bit, halt_request_bit, lk.cyc}, 0);
    // the refused write leaves the key armed; spend it
    wr(CSCB_ADDR_STANDBY, 32'h0);
    $display("test standby done");
    wr(CSCB_ADDR_CLKMUL, CSCB_KEY);
    wr(CSCB_ADDR_CLKMUL, 3);
    wr(CSCB_ADDR_STANDBY, CSCB_KEY);
    @(posedge clk_i);
    wdog <= 1'b1;
    @(posedge clk_i);
    wdog <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk("watchdog reset", sr, 1'b1);
    chk("fetch in reset", pc, CSCB_EXEC_START);
    repeat (12) @(negedge clk_i);
    src = 1;
    arm = '{0, 0};
    rd(CSCB_ADDR_RSTSRC);
    rd(CSCB_ADDR_CLKMUL);
    rd(CSCB_ADDR_CLKWAIT);
    chk("multiplier kept", mul_o, mul);
    chk("wait kept", wt_o, wt);
    wr(CSCB_ADDR_STANDBY, 32'h1);
    repeat (3) @(negedge clk_i);
    chk("unkeyed halt", halt_request_bit, 0);
    $display("test watchdog done");
    @(posedge clk_i);
    rst_pin_n <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk("pin reset", sr, 1'b1);
    chk("pin reset fetch", pc, CSCB_EXEC_START);
    @(posedge clk_i);
    rst_pin_n <= 1'b1;
    n = 0;
    do @(negedge clk_i); while (sr !== 1'b0 && ++n < 50);
    chk("pin reset span", n inside {[10:13]}, 1);
    {mul, wt, src} = '0;
    rd(CSCB_ADDR_RSTSRC);
    rd(CSCB_ADDR_CLKMUL);
    $display("test pin reset done");
    for (int i = 0; i < 4; i++) begin
      b = ck_o;
      @(negedge clk_i);
      chk("clock output", ck_o, !b);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      pll <= i[0];
      repeat (4) @(negedge clk_i);
      chk("pll active", pll_o, i[0]);
    end
    $display("test pins done");
    wrap_up();
  end
endmodule
